// file: wdt_pkg.sv
// Constants, types and decode helpers shared by the watchdog and reset block
package wdt_pkg;
	localparam logic [7:0] WATCHDOG_CONTROL_POR = 8'h53;
	localparam logic [7:0] LVL_POR = 8'h55;
	localparam logic [4:0] KEY_OFF = 5'h15;
	localparam logic [4:0] KEY_ON = 5'h0a;
	localparam logic [7:0] LVL_3V8 = 8'haa;
	localparam logic [7:0] LVL_2V1 = 8'h55;
	localparam logic [7:0] LVL_2V55 = 8'h33;
	localparam logic [7:0] LVL_3V15 = 8'h99;
	localparam int KEY_HI = 7;
	localparam int KEY_LO = 3;
	localparam int SEL_HI = 2;
	localparam int KEEP_BIT = 7;
	localparam int SDF_BIT = 2;
	localparam int LCF_BIT = 1;
	localparam int KF_BIT = 0;
	localparam int EXP_BIT = 0;
	localparam int SLP_BIT = 1;
	localparam int RST_BIT = 2;
	localparam int ADDR_W = 4;
	localparam logic [3:0] A_WATCHDOG_CONTROL = 4'h0;
	localparam logic [3:0] A_MODE = 4'h4;
	localparam logic [3:0] A_LVL = 4'h8;
	localparam logic [3:0] A_STAT = 4'hc;
	localparam int CLK_NS = 100;
	localparam int PIN_REL_NS = 1000;
	localparam int PIN_REL_CYC = (PIN_REL_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW_QUAL_NS = 100000;
	localparam int LOW_QUAL_CYC = (LOW_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int SST_FAST = 16;
	localparam int SST_XTAL = 1024;
	localparam int SST_SLOW = 2;
	localparam int DEB_TICKS = 3;
	localparam int WDT_W = 18;
	typedef enum logic [2:0] {OSC_EXT_RC, OSC_FAST_RC, OSC_FAST_XTAL, OSC_WATCH_XTAL,
		OSC_SLOW_RC} osc_e;
	typedef enum logic [1:0] {ST_START, ST_RUN, ST_HOLD, ST_WAIT} rst_st_e;

	function automatic logic [4:0] period_exp(input logic [2:0] s);
		logic [4:0] e;
		e = 5'h08;
		unique case (s)
			3'h0: e = 5'h08;
			3'h1: e = 5'h0a;
			3'h2: e = 5'h0c;
			3'h3: e = 5'h0e;
			3'h4: e = 5'h0f;
			3'h5: e = 5'h10;
			3'h6: e = 5'h11;
			3'h7: e = 5'h12;
		endcase
		return e;
	endfunction : period_exp

	function automatic logic [10:0] sst_cycles(input osc_e o);
		logic [10:0] c;
		c = 11'(SST_FAST);
		if (o == OSC_FAST_XTAL || o == OSC_WATCH_XTAL)
			c = 11'(SST_XTAL);
		else if (o == OSC_SLOW_RC)
			c = 11'(SST_SLOW);
		return c;
	endfunction : sst_cycles
endpackage : wdt_pkg

// file: wdt_if.sv
// Link between reset control and the watchdog counter
interface wdt_if;
	logic enable;
	logic [2:0] period_sel;
	logic clear;
	logic overflow;
	modport ctrl (output enable, output period_sel, output clear, input overflow);
	modport cnt (input enable, input period_sel, input clear, output overflow);
endinterface : wdt_if

// file: wdt_counter.sv
// Watchdog counter with clock source choice and period selection
module wdt_counter #(
	parameter int CNT_W = 18
) (
	input wire logic clk, // System clock
	input wire logic rst_b, // Power-on reset
	input wire logic sub_tick, // Slow clock tick
	input wire logic src_sub, // 1 slow clock, 0 system clock / 4
	wdt_if.cnt w // Control and overflow
);
	import wdt_pkg::*;
	typedef struct packed {
		logic [1:0] div;
		logic [CNT_W-1:0] cnt;
		logic ovf;
	} cnt_s;
	cnt_s s_q, s_d;
	logic tick;
	logic [CNT_W:0] lim;

	generate
		if (CNT_W < WDT_W)
			$error("wdt_counter: CNT_W too small for longest period");
	endgenerate

	always_comb
	begin
		s_d = s_q;
		s_d.div = s_q.div + 2'h1;
		tick = src_sub ? sub_tick : (s_q.div == 2'h3);
		lim = ({{CNT_W{1'b0}}, 1'b1} << period_exp(w.period_sel)) - 1'b1;
		s_d.ovf = 1'b0;
		if (!w.enable || w.clear)
			s_d.cnt = '0;
		else if (tick)
		begin
			if (s_q.cnt == lim[CNT_W-1:0])
			begin
				s_d.cnt = '0;
				s_d.ovf = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;

	assign w.overflow = s_q.ovf;
endmodule : wdt_counter

// file: key_debounce.sv
// Delays a reset request from an invalid code by whole slow RC periods
module key_debounce #(
	parameter int TICKS = 3
) (
	input wire logic clk, // System clock
	input wire logic rst_b, // Power-on reset
	input wire logic bad, // Invalid code present
	input wire logic tick, // Slow RC tick
	output logic fire // One-cycle reset request
);
	typedef struct packed {
		logic [3:0] n;
		logic fire;
	} deb_s;
	deb_s s_q, s_d;

	generate
		if (TICKS < 1 || TICKS > 15)
			$error("key_debounce: TICKS out of range");
	endgenerate

	// Fires on the third tick, so 2 to 3 periods after the code appears
	always_comb
	begin
		s_d = s_q;
		s_d.fire = 1'b0;
		if (!bad)
			s_d.n = 4'h0;
		else if (tick && s_q.n != 4'(TICKS))
		begin
			s_d.n = s_q.n + 4'h1;
			s_d.fire = (s_q.n == 4'(TICKS - 1));
		end
	end

	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;

	assign fire = s_q.fire;
endmodule : key_debounce

// file: wdt_reset_ctrl.sv
// Watchdog and reset-source control with AHB-Lite register access
//
// Added by the designer: register access over AHB-Lite and the register addresses.
module wdt_reset_ctrl (
	input wire logic clk, // System clock
	input wire logic rst_b, // Power-on reset
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	input wire logic clear_watchdog_instr_instr, // Clear-watchdog instruction pulse
	input wire logic halt_instr, // Halt instruction pulse
	input wire logic in_sleep_idle, // Core in sleep or idle
	input wire logic ext_clear_pin_b, // External clear pin
	input wire logic supply_low, // Supply below chosen level
	input wire logic slow_rc_tick, // Slow RC tick pulse
	input wire logic sub_clk_tick, // Slow sub clock tick pulse
	input wire logic wdt_src_sub, // Watchdog clock option
	input wire wdt_pkg::osc_e osc_sel, // System oscillator type
	output logic sys_reset, // Full reset, PC zero, ports high
	output logic pc_sp_clear, // Clear PC and SP only
	output logic exec_en, // Execution allowed
	output logic idle_sysclk_keep, // Keep clock in idle
	output logic watchdog_expired_flag, // Watchdog expired
	output logic sleep_entry_flag, // Halt executed
	output logic [7:0] drop_level_code // Level for detector
);
	import wdt_pkg::*;
	typedef struct packed {
		logic [7:0] watchdog_control;
		logic [7:0] lvl;
		logic keep;
		logic fsd;
		logic flc;
		logic fkf;
		logic expired;
		logic sleep_entry;
		rst_st_e st;
		logic [10:0] cnt;
		logic [10:0] low_cnt;
		logic act;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0] rdata;
		logic rdy;
		logic sys_rst;
		logic pcsp;
		logic run;
	} ctrl_s;
	ctrl_s s_q, s_d;

	localparam ctrl_s CTRL_POR = '{
		watchdog_control: WATCHDOG_CONTROL_POR,
		lvl: LVL_POR,
		keep: 1'b0,
		fsd: 1'b0,
		flc: 1'b0,
		fkf: 1'b0,
		expired: 1'b0,
		sleep_entry: 1'b0,
		st: ST_START,
		cnt: 11'h000,
		low_cnt: 11'h000,
		act: 1'b0,
		wr: 1'b0,
		addr: '0,
		rdata: 32'h0000_0000,
		rdy: 1'b1,
		sys_rst: 1'b1,
		pcsp: 1'b0,
		run: 1'b0
	};

	wdt_if w ();
	logic key_bad, lvl_bad, key_fire, lvl_fire;
	logic take, hit, drop_fire, drop_hold, pin_hold, wdt_rst, full_evt;

	function automatic logic level_ok(input logic [7:0] c);
		return c == LVL_3V8 || c == LVL_2V1 || c == LVL_2V55 || c == LVL_3V15;
	endfunction : level_ok

	assign key_bad = s_q.watchdog_control[KEY_HI:KEY_LO] != KEY_OFF
		&& s_q.watchdog_control[KEY_HI:KEY_LO] != KEY_ON;
	assign lvl_bad = !level_ok(s_q.lvl);

	key_debounce #(
		.TICKS(DEB_TICKS)
	) u_key_deb (
		.clk(clk),
		.rst_b(rst_b),
		.bad(key_bad),
		.tick(slow_rc_tick),
		.fire(key_fire)
	);

	key_debounce #(
		.TICKS(DEB_TICKS)
	) u_lvl_deb (
		.clk(clk),
		.rst_b(rst_b),
		.bad(lvl_bad),
		.tick(slow_rc_tick),
		.fire(lvl_fire)
	);

	wdt_counter #(
		.CNT_W(WDT_W)
	) u_cnt (
		.clk(clk),
		.rst_b(rst_b),
		.sub_tick(sub_clk_tick),
		.src_sub(wdt_src_sub),
		.w(w.cnt)
	);

	// Only the disable code stops counting; bad codes reset soon anyway
	assign w.enable = s_q.watchdog_control[KEY_HI:KEY_LO] != KEY_OFF;
	assign w.period_sel = s_q.watchdog_control[SEL_HI:0];
	assign w.clear = clear_watchdog_instr_instr || halt_instr || s_q.sys_rst;

	always_comb
	begin
		s_d = s_q;
		s_d.pcsp = 1'b0;
		s_d.rdy = 1'b1;
		take = hsel && htrans[1] && hready;
		hit = haddr[31:ADDR_W] == '0;

		// Data phase writes come first so hardware sets below win
		if (s_q.act && s_q.wr)
		begin
			unique case (s_q.addr)
				A_WATCHDOG_CONTROL: s_d.watchdog_control = hwdata[7:0];
				A_MODE:
				begin
					s_d.keep = hwdata[KEEP_BIT];
					s_d.fsd = s_q.fsd & hwdata[SDF_BIT];
					s_d.flc = s_q.flc & hwdata[LCF_BIT];
					s_d.fkf = s_q.fkf & hwdata[KF_BIT];
				end
				A_LVL: s_d.lvl = hwdata[7:0];
				default: ;
			endcase
		end

		if (clear_watchdog_instr_instr)
		begin
			s_d.expired = 1'b0;
			s_d.sleep_entry = 1'b0;
		end
		if (halt_instr)
		begin
			s_d.expired = 1'b0;
			s_d.sleep_entry = 1'b1;
		end

		// Low supply must persist before it counts as a drop
		if (supply_low)
		begin
			if (s_q.low_cnt != 11'(LOW_QUAL_CYC))
				s_d.low_cnt = s_q.low_cnt + 11'h001;
		end
		else
			s_d.low_cnt = 11'h000;
		drop_fire = supply_low && s_q.low_cnt == 11'(LOW_QUAL_CYC - 1);
		drop_hold = supply_low && s_q.low_cnt == 11'(LOW_QUAL_CYC);
		pin_hold = !ext_clear_pin_b;
		wdt_rst = w.overflow && !in_sleep_idle;

		if (w.overflow)
		begin
			s_d.expired = 1'b1;
			if (in_sleep_idle)
				s_d.pcsp = 1'b1;
		end
		if (key_fire)
			s_d.fkf = 1'b1;
		if (drop_fire)
			s_d.fsd = 1'b1;

		full_evt = pin_hold || drop_fire || drop_hold || key_fire
			|| lvl_fire || wdt_rst;
		if (full_evt)
		begin
			s_d.st = ST_HOLD;
			s_d.sys_rst = 1'b1;
			s_d.run = 1'b0;
			s_d.watchdog_control = WATCHDOG_CONTROL_POR;
			s_d.keep = 1'b0;
			s_d.act = 1'b0;
			if (!(drop_fire || drop_hold) || lvl_fire)
				s_d.lvl = LVL_POR;
		end
		if (lvl_fire)
			s_d.flc = 1'b1;

		if (!full_evt)
		begin
			unique case (s_q.st)
				ST_START:
				begin
					s_d.cnt = sst_cycles(osc_sel);
					s_d.st = ST_WAIT;
				end
				ST_HOLD:
				begin
					s_d.cnt = 11'(PIN_REL_CYC);
					s_d.st = ST_WAIT;
				end
				ST_WAIT:
				begin
					s_d.cnt = s_q.cnt - 11'h001;
					if (s_q.cnt <= 11'h001)
					begin
						s_d.st = ST_RUN;
						s_d.sys_rst = 1'b0;
						s_d.run = 1'b1;
					end
				end
				ST_RUN: ;
			endcase
		end

		// Address phase; read data built from next state so back-to-back
		// write then read returns the new value
		if (!full_evt || s_q.st == ST_RUN)
		begin
			s_d.act = take;
			s_d.wr = hwrite;
			s_d.addr = hit ? haddr[ADDR_W-1:0] : 4'h2;
		end
		s_d.rdata = 32'h0000_0000;
		if (take && !hwrite && hit)
		begin
			unique case (haddr[ADDR_W-1:0])
				A_WATCHDOG_CONTROL: s_d.rdata[7:0] = s_d.watchdog_control;
				A_MODE:
				begin
					s_d.rdata[KEEP_BIT] = s_d.keep;
					s_d.rdata[SDF_BIT] = s_d.fsd;
					s_d.rdata[LCF_BIT] = s_d.flc;
					s_d.rdata[KF_BIT] = s_d.fkf;
				end
				A_LVL: s_d.rdata[7:0] = s_d.lvl;
				A_STAT:
				begin
					s_d.rdata[EXP_BIT] = s_d.expired;
					s_d.rdata[SLP_BIT] = s_d.sleep_entry;
					s_d.rdata[RST_BIT] = s_d.sys_rst;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			s_q <= CTRL_POR;
		else
			s_q <= s_d;

	assign hrdata = s_q.rdata;
	assign hreadyout = s_q.rdy;
	assign hresp = 1'b0 & s_q.rdy;
	assign sys_reset = s_q.sys_rst;
	assign pc_sp_clear = s_q.pcsp;
	assign exec_en = s_q.run;
	assign idle_sysclk_keep = s_q.keep;
	assign watchdog_expired_flag = s_q.expired;
	assign sleep_entry_flag = s_q.sleep_entry;
	assign drop_level_code = s_q.lvl;
endmodule : wdt_reset_ctrl

// file: wdt_reset_ctrl_properties.sv
// Port-level checks for the watchdog and reset block
module wdt_reset_ctrl_properties
	import wdt_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_b, // Power-on reset
	input wire logic ext_clear_pin_b, // Clear pin
	input wire logic supply_low, // Low supply
	input wire logic halt_instr, // Halt pulse
	input wire logic clear_watchdog_instr_instr, // Clear pulse
	input wire logic sys_reset, // Full reset
	input wire logic pc_sp_clear, // Sleep overflow
	input wire logic exec_en, // Run allowed
	input wire logic idle_sysclk_keep, // Idle clock keep
	input wire logic watchdog_expired_flag, // Expired
	input wire logic sleep_entry_flag // Halt seen
);
	logic [10:0] low_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Saturates so a long brown-out never wraps back to short
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			low_q <= '0;
		else
			low_q <= supply_low ? low_q + 11'(low_q < 11'h7ff) : '0;

	chk_run_gate: assert property (exec_en == !sys_reset)
		else $error("exec_en not inverse of sys_reset");
	chk_pin_reset: assert property (!ext_clear_pin_b |=> sys_reset)
		else $error("pin low without reset");
	chk_pin_delay: assert property ($rose(ext_clear_pin_b) |-> !exec_en [*8])
		else $error("run resumed too soon after pin");
	chk_drop_qual: assert property (low_q == 11'(LOW_QUAL_CYC) |-> ##[0:3] sys_reset)
		else $error("long supply drop without reset");
	chk_sleep_pulse: assert property (pc_sp_clear |-> !sys_reset ##1 !pc_sp_clear)
		else $error("sleep overflow pulse wrong");
	chk_sleep_expire: assert property (pc_sp_clear |-> ##[0:1] watchdog_expired_flag)
		else $error("expired flag not set in sleep");
	chk_halt_flag: assert property (halt_instr && exec_en |-> ##[1:2] sleep_entry_flag)
		else $error("halt did not set sleep flag");
	chk_clr_flags: assert property (clear_watchdog_instr_instr && exec_en
		|-> ##[1:2] !(watchdog_expired_flag || sleep_entry_flag))
		else $error("clear did not drop flags");
	chk_por_state: assert property ($rose(rst_b)
		|-> sys_reset && !watchdog_expired_flag && !sleep_entry_flag)
		else $error("power-on state wrong");
	chk_keep_drop: assert property ($rose(sys_reset) |-> ##[0:2] !idle_sysclk_keep)
		else $error("keep bit survived reset");
endmodule : wdt_reset_ctrl_properties

bind wdt_reset_ctrl wdt_reset_ctrl_properties i_wdt_reset_ctrl_properties (.clk, .rst_b,
	.ext_clear_pin_b, .supply_low, .halt_instr, .clear_watchdog_instr_instr, .sys_reset, .pc_sp_clear,
	.exec_en, .idle_sysclk_keep, .watchdog_expired_flag, .sleep_entry_flag);

// file: test_wdt_reset_ctrl.sv
// Self-checking bench for the watchdog and reset block
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_wdt_reset_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_ph = 1'h0, sub_en = 1'h0;
	logic clear_watchdog_instr_instr = 1'h0, halt_instr = 1'h0, in_sleep_idle = 1'h0, supply_low = 1'h0;
	logic ext_clear_pin_b = 1'h1, slow_rc_tick = 1'h0, sub_clk_tick = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, exp_q[$];
	logic hreadyout, hresp, sys_reset, pc_sp_clear, exec_en;
	logic idle_sysclk_keep, watchdog_expired_flag, sleep_entry_flag;
	logic [7:0] drop_level_code;
	logic [7:0] lv[4] = '{LVL_3V8, LVL_2V55, LVL_3V15, LVL_2V1};
	int cyc = 0, n_fail = 0, checks = 0, n;

	wdt_reset_ctrl i_wdt_reset_ctrl (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.clear_watchdog_instr_instr, .halt_instr, .in_sleep_idle, .ext_clear_pin_b, .supply_low,
		.slow_rc_tick, .sub_clk_tick, .wdt_src_sub(1'h1), .osc_sel(OSC_SLOW_RC), .sys_reset,
		.pc_sp_clear, .exec_en, .idle_sysclk_keep, .watchdog_expired_flag,
		.sleep_entry_flag, .drop_level_code);

	initial
		forever #50 clk = ~clk;

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// Slow RC ticks every 8 clocks; sub clock ticks only when asked
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		slow_rc_tick <= (cyc % 8 == 7);
		sub_clk_tick <= sub_en;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	always @(posedge clk)
		if (rd_ph)
		begin
			`CHK(hrdata, exp_q[0])
			void'(exp_q.pop_front());
		end

	// For a read, d is the expected data
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		if (!w)
			exp_q.push_back(d);
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd_ph <= 1'h0;
	endtask : bus

	task automatic wait_run(input logic v);
		n = 0;
		while (exec_en !== v)
		begin
			@(posedge clk);
			n++;
		end
	endtask : wait_run

	task automatic pulse(input logic clr);
		if (clr)
			clear_watchdog_instr_instr <= 1'h1;
		else
			halt_instr <= 1'h1;
		@(posedge clk);
		clear_watchdog_instr_instr <= 1'h0;
		halt_instr <= 1'h0;
	endtask : pulse

	initial
	begin
		logic [31:0] r;
		void'($urandom(32'h2b03));
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		wait_run(1'h1);
		bus(A_WATCHDOG_CONTROL, 1'h0, 32'h53);
		bus(A_MODE, 1'h0, 32'h0);
		bus(A_LVL, 1'h0, 32'h55);
		bus(32'h20, 1'h1, 32'hff);
		bus(32'h20, 1'h0, 32'h0);
		r = $urandom;
		bus(A_WATCHDOG_CONTROL, 1'h1, {24'h0, KEY_OFF, r[2:0]});
		bus(A_WATCHDOG_CONTROL, 1'h0, {24'h0, KEY_OFF, r[2:0]});
		bus(A_MODE, 1'h1, {24'h0, r[7], 7'h7f});
		bus(A_MODE, 1'h0, {24'h0, r[7], 7'h0});
		foreach (lv[i])
		begin
			bus(A_LVL, 1'h1, {24'h0, lv[i]});
			bus(A_LVL, 1'h0, {24'h0, lv[i]});
		end
		$display("registers done");
		bus(A_WATCHDOG_CONTROL, 1'h1, 32'h50);
		sub_en <= 1'h1;
		repeat (200) @(posedge clk);
		pulse(1'h1);
		repeat (200) @(posedge clk);
		bus(A_STAT, 1'h0, 32'h0);
		wait_run(1'h0);
		sub_en <= 1'h0;
		wait_run(1'h1);
		bus(A_STAT, 1'h0, 32'h1);
		bus(A_WATCHDOG_CONTROL, 1'h0, 32'h53);
		bus(A_WATCHDOG_CONTROL, 1'h1, 32'ha8);
		sub_en <= 1'h1;
		repeat (300) @(posedge clk);
		sub_en <= 1'h0;
		bus(A_STAT, 1'h0, 32'h1);
		pulse(1'h1);
		bus(A_STAT, 1'h0, 32'h0);
		$display("overflow done");
		pulse(1'h0);
		bus(A_STAT, 1'h0, 32'h2);
		bus(A_MODE, 1'h1, 32'h80);
		bus(A_WATCHDOG_CONTROL, 1'h1, 32'h50);
		in_sleep_idle <= 1'h1;
		sub_en <= 1'h1;
		while (pc_sp_clear !== 1'h1)
			@(posedge clk);
		sub_en <= 1'h0;
		in_sleep_idle <= 1'h0;
		bus(A_STAT, 1'h0, 32'h3);
		bus(A_MODE, 1'h0, 32'h80);
		bus(A_WATCHDOG_CONTROL, 1'h0, 32'h50);
		`CHK({idle_sysclk_keep, watchdog_expired_flag, sleep_entry_flag}, 3'h7)
		$display("sleep done");
		bus(A_WATCHDOG_CONTROL, 1'h1, 32'h0);
		wait_run(1'h0);
		`CHK(n inside {[16:28]}, 1'h1)
		wait_run(1'h1);
		bus(A_MODE, 1'h0, 32'h1);
		bus(A_MODE, 1'h1, 32'h0);
		bus(A_MODE, 1'h0, 32'h0);
		bus(A_LVL, 1'h1, 32'h12);
		wait_run(1'h0);
		wait_run(1'h1);
		bus(A_LVL, 1'h0, 32'h55);
		bus(A_MODE, 1'h0, 32'h2);
		$display("code faults done");
		bus(A_LVL, 1'h1, 32'haa);
		supply_low <= 1'h1;
		repeat (500) @(posedge clk);
		supply_low <= 1'h0;
		bus(A_STAT, 1'h0, 32'h3);
		supply_low <= 1'h1;
		wait_run(1'h0);
		supply_low <= 1'h0;
		wait_run(1'h1);
		bus(A_MODE, 1'h0, 32'h6);
		bus(A_LVL, 1'h0, 32'haa);
		`CHK(drop_level_code, 8'haa)
		bus(A_MODE, 1'h1, 32'h80);
		bus(A_MODE, 1'h0, 32'h80);
		$display("supply drop done");
		ext_clear_pin_b <= 1'h0;
		repeat (5) @(posedge clk);
		bus(A_STAT, 1'h0, 32'h7);
		ext_clear_pin_b <= 1'h1;
		wait_run(1'h1);
		`CHK(n >= PIN_REL_CYC, 1'h1)
		bus(A_MODE, 1'h0, 32'h0);
		pulse(1'h0);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		wait_run(1'h1);
		bus(A_STAT, 1'h0, 32'h0);
		bus(A_MODE, 1'h0, 32'h0);
		$display("pin and power-on done");
		stop_test();
	end
endmodule : test_wdt_reset_ctrl
